/* File: rtl/anc_autoneg_ctrl.sv */
`include "anc_defines.svh"
// Behaviour
// - strap enable low: mode straps force 10/100 and half/full duplex.
// - strap enable high: mode straps choose which of four abilities are advertised.
// - straps sampled after reset load advertisement bits 8 to 5.
// - software may rewrite the control register at offset zero anytime.
// - while negotiating, advertisement register at offset four is sent in bursts.
// - mode straps never change the control register contents.
// - summary register gives complete, duplex, speed; duplex/speed valid when settled.
// - highest common mode chosen: 100 full, 100 half, 10 full, 10 half.
// - control speed and duplex bits apply only with negotiation disabled.
// - status ability bits hard-wired; the T4 ability reads zero.
// - status also shows complete, remote fault, link valid, preamble suppression.
// - advertisement defaults to the strap-selected abilities; software may clear bits to suppress.
// - partner register at offset five captures base and next page words.
// - parallel detect completion loads partner with 0081h or 0021h.
// - expansion register shows detect fault, partner next page ability, page received, partner able.
// - both receivers' link status feed parallel detection of a silent partner.
// - after parallel detect, partner-able reads zero while complete reads one.
// - parallel detect fault set when both receivers report good link before a page.
// - writing one to control bit 9 restarts negotiation.
// - link lost after negotiation resumes negotiation automatically.
// - any restart silences transmitter for the break interval, then bursts resume.
module anc_autoneg_ctrl #(
    parameter int BREAK_LINK_MS = `ANC_BREAK_LINK_MS,
    parameter int CLK_HZ = `ANC_CLK_HZ
) (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    // strap pins
    input wire logic negotiate_strap_enable_in,
    input wire logic mode_strap_high_in,
    input wire logic mode_strap_low_in,
    // receiver link status
    input wire logic link_10_good_in,
    input wire logic link_100_good_in,
    // received code words from the pulse decoder
    input wire logic page_valid_in,
    input wire logic [15:0] page_word_in,
    // management register access
    input wire anc_pkg::anc_reg_req_t reg_req_in,
    output anc_pkg::anc_mode_t mode_out,
    output logic [15:0] reg_rdata_out,
    // transmit control
    output logic flp_enable_out,
    output logic [15:0] flp_word_out,
    output logic tx_quiet_out
);
    // break length in core cycles, so a slower clock figure shortens it
    localparam int unsigned BREAK_CYC = BREAK_LINK_MS * (CLK_HZ / 1000);
    localparam int CNT_W = $clog2(BREAK_CYC + 1);

    anc_pkg::anc_state_t state_r, state_nxt;
    logic [4:0] pin_r;
    logic [2:0] settle_r;
    logic link_seen_r;
    logic straps_loaded_r;
    logic strap_an_r, strap_hi_r, strap_lo_r;
    logic [15:0] control_r, advert_r, partner_r;
    logic sw_override_r, an_cleared_r, an_eff_prev_r;
    logic pd_fault_r, page_rx_r, lp_an_able_r;
    logic [CNT_W-1:0] break_cnt_r;

    // synchronise pins: three flops, change taken when second and third agree
    // the first flop feeds only the shift, so a metastable value never spreads
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            wire logic pin_raw;
            assign pin_raw = (gi == 0) ? negotiate_strap_enable_in :
                             (gi == 1) ? mode_strap_high_in :
                             (gi == 2) ? mode_strap_low_in :
                             (gi == 3) ? link_10_good_in : link_100_good_in;
            logic [2:0] sh_r;
            always_ff @(posedge sys_clk_in) begin
                if (!reset_n_in) begin
                    sh_r <= 3'h0;
                    pin_r[gi] <= 1'b0;
                end else if (ce_in) begin
                    sh_r <= {sh_r[1:0], pin_raw};
                    if (sh_r[1] == sh_r[2])
                        pin_r[gi] <= sh_r[2];
                end
            end
        end
    endgenerate

    wire logic link10 = pin_r[3];
    wire logic link100 = pin_r[4];

    // strap decode
    // advertised pattern for each mode strap pair
    wire logic [3:0] strap_adv = ({pin_r[1], pin_r[2]} == 2'h0) ? `ANC_ADV_10_BOTH :
                                 ({pin_r[1], pin_r[2]} == 2'h1) ? `ANC_ADV_100_BOTH :
                                 ({pin_r[1], pin_r[2]} == 2'h2) ? `ANC_ADV_HALF_ONLY :
                                 `ANC_ADV_ALL;

    // register access decode
    wire logic wr_ctl = reg_req_in.wr && reg_req_in.addr == `ANC_OFS_CONTROL;
    wire logic wr_adv = reg_req_in.wr && reg_req_in.addr == `ANC_OFS_ADVERT;
    wire logic rd_exp = reg_req_in.rd && reg_req_in.addr == `ANC_OFS_EXPANSION;
    wire logic restart_wr = wr_ctl && reg_req_in.wdata[`ANC_CTL_RESTART];

    // effective enable: forced start needs bit 12 cleared first
    wire logic an_eff = sw_override_r ? (control_r[`ANC_CTL_NEGOTIATE_STRAP_ENABLE] && (strap_an_r || an_cleared_r))
                                      : strap_an_r;
    wire logic an_rise = an_eff && !an_eff_prev_r;

    // resolution of common abilities
    wire logic [3:0] common = advert_r[`ANC_ABL_HI:`ANC_ABL_LO] & partner_r[`ANC_ABL_HI:`ANC_ABL_LO];
    wire logic res_100 = common[`ANC_ABL_100F - `ANC_ABL_LO] || common[`ANC_ABL_100H - `ANC_ABL_LO];
    wire logic res_full = common[`ANC_ABL_100F - `ANC_ABL_LO] ||
                          (!res_100 && common[`ANC_ABL_10F - `ANC_ABL_LO]);

    // page events
    wire logic [3:0] page_common = advert_r[`ANC_ABL_HI:`ANC_ABL_LO] & page_word_in[`ANC_ABL_HI:`ANC_ABL_LO];
    wire logic page_done = page_valid_in && page_word_in[`ANC_PG_ACK] && !page_word_in[`ANC_PG_NEXT] &&
                           (page_common != 4'h0);
    wire logic one_link = link10 ^ link100;
    wire logic pd_done = !page_rx_r && one_link;
    wire logic link_ok = res_100 ? link100 : link10;
    // link loss only counts once the resolved link has been seen;
    // the receivers' sync delay would otherwise drop a fresh result at once
    wire logic link_lost = link_seen_r && !link_ok;
    wire logic break_done = break_cnt_r == '0;

    // forced and resolved mode
    wire logic forced_100 = sw_override_r ? control_r[`ANC_CTL_SPEED] : strap_hi_r;
    wire logic forced_full = sw_override_r ? control_r[`ANC_CTL_DUPLEX] : strap_lo_r;
    wire logic cur_100 = an_eff ? res_100 : forced_100;
    wire logic cur_full = an_eff ? res_full : forced_full;
    wire logic cur_link = cur_100 ? link100 : link10;
    wire logic done = state_r == anc_pkg::ANC_COMPLETE;

    // sequencer next state
    // a restart write during the break reloads the counter and holds the state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            anc_pkg::ANC_FORCED: begin
                if (an_eff)
                    state_nxt = anc_pkg::ANC_BREAK;
            end
            anc_pkg::ANC_BREAK: begin
                if (!an_eff)
                    state_nxt = anc_pkg::ANC_FORCED;
                else if (break_done && !restart_wr)
                    state_nxt = anc_pkg::ANC_ABILITY;
            end
            anc_pkg::ANC_ABILITY: begin
                if (!an_eff)
                    state_nxt = anc_pkg::ANC_FORCED;
                else if (restart_wr)
                    state_nxt = anc_pkg::ANC_BREAK;
                else if (page_done || pd_done)
                    state_nxt = anc_pkg::ANC_COMPLETE;
            end
            anc_pkg::ANC_COMPLETE: begin
                if (!an_eff)
                    state_nxt = anc_pkg::ANC_FORCED;
                else if (restart_wr || link_lost)
                    state_nxt = anc_pkg::ANC_BREAK;
            end
        endcase
    end

    // state, strap capture and break counter
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            state_r <= anc_pkg::ANC_FORCED;
            settle_r <= 2'h0;
            straps_loaded_r <= 1'b0;
            strap_an_r <= 1'b0;
            strap_hi_r <= 1'b0;
            strap_lo_r <= 1'b0;
            an_eff_prev_r <= 1'b0;
            link_seen_r <= 1'b0;
            break_cnt_r <= CNT_W'(BREAK_CYC);
        end else if (ce_in) begin
            // straps latched only once the synchroniser has filled
            if (!straps_loaded_r) begin
                if (settle_r == `ANC_STRAP_SETTLE) begin
                    straps_loaded_r <= 1'b1;
                    strap_an_r <= pin_r[0];
                    strap_hi_r <= pin_r[1];
                    strap_lo_r <= pin_r[2];
                end else begin
                    settle_r <= settle_r + 3'h1;
                end
            end else begin
                state_r <= state_nxt;
                an_eff_prev_r <= an_eff;
                link_seen_r <= done && (link_seen_r || link_ok);
            end
            if (an_rise || restart_wr || (state_r != anc_pkg::ANC_BREAK))
                break_cnt_r <= CNT_W'(BREAK_CYC);
            else if (!break_done)
                break_cnt_r <= break_cnt_r - CNT_W'(1);
        end
    end

    // control and advertisement registers
    // restart bit self-clears so a read never shows a pending restart
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            control_r <= `ANC_CTL_RESET_VAL;
            advert_r <= `ANC_SELECTOR;
            sw_override_r <= 1'b0;
            an_cleared_r <= 1'b0;
        end else if (ce_in) begin
            if (!straps_loaded_r && settle_r == `ANC_STRAP_SETTLE)
                advert_r[`ANC_ABL_HI:`ANC_ABL_LO] <= strap_adv;
            else if (wr_adv)
                advert_r <= reg_req_in.wdata;
            if (wr_ctl) begin
                control_r <= reg_req_in.wdata & ~(16'h1 << `ANC_CTL_RESTART);
                sw_override_r <= 1'b1;
                if (!reg_req_in.wdata[`ANC_CTL_NEGOTIATE_STRAP_ENABLE])
                    an_cleared_r <= 1'b1;
            end
        end
    end

    // partner word and expansion flags, set wins over read clear
    // a page and a parallel detect in one cycle: the page is kept
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            partner_r <= 16'h0;
            pd_fault_r <= 1'b0;
            page_rx_r <= 1'b0;
            lp_an_able_r <= 1'b0;
        end else if (ce_in) begin
            if (state_r == anc_pkg::ANC_BREAK) begin
                lp_an_able_r <= 1'b0;
                page_rx_r <= 1'b0;
            end else if (state_r == anc_pkg::ANC_ABILITY) begin
                if (page_valid_in) begin
                    partner_r <= page_word_in;
                    lp_an_able_r <= 1'b1;
                end else if (pd_done) begin
                    partner_r <= link100 ? `ANC_PD_100_WORD : `ANC_PD_10_WORD;
                    lp_an_able_r <= 1'b0;
                end
            end
            if (state_r == anc_pkg::ANC_ABILITY && page_valid_in)
                page_rx_r <= 1'b1;
            else if (rd_exp)
                page_rx_r <= 1'b0;
            if (state_r == anc_pkg::ANC_ABILITY && !page_rx_r && link10 && link100)
                pd_fault_r <= 1'b1;
            else if (rd_exp)
                pd_fault_r <= 1'b0;
        end
    end

    // status words
    wire logic [15:0] status_word = `ANC_STS_FIXED
        | (16'(done) << `ANC_STS_AN_DONE)
        | (16'(partner_r[`ANC_PG_RFAULT]) << `ANC_STS_RFAULT)
        | (16'(cur_link) << `ANC_STS_LINK);
    wire logic settled = !an_eff || done;
    wire logic [15:0] expansion_word = (16'(pd_fault_r) << `ANC_EXP_PD_FAULT)
        | (16'(partner_r[`ANC_PG_NEXT]) << `ANC_EXP_LP_NP)
        | (16'(page_rx_r) << `ANC_EXP_PAGE_RX)
        | (16'(lp_an_able_r) << `ANC_EXP_LP_AN);
    wire logic [15:0] summary_word = (16'(cur_link) << `ANC_SUM_LINK)
        | (16'(settled && !cur_100) << `ANC_SUM_SPEED10)
        | (16'(settled && cur_full) << `ANC_SUM_DUPLEX)
        | (16'(done) << `ANC_SUM_AN_DONE);
    // unmapped offsets read as zero
    wire logic [15:0] rd_mux = (reg_req_in.addr == `ANC_OFS_CONTROL) ? control_r :
                               (reg_req_in.addr == `ANC_OFS_STATUS) ? status_word :
                               (reg_req_in.addr == `ANC_OFS_ADVERT) ? advert_r :
                               (reg_req_in.addr == `ANC_OFS_PARTNER) ? partner_r :
                               (reg_req_in.addr == `ANC_OFS_EXPANSION) ? expansion_word :
                               (reg_req_in.addr == `ANC_OFS_SUMMARY) ? summary_word : 16'h0;

    // registered outputs
    // read data holds between reads; quiet also covers the strap settle time
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 16'h0;
            flp_enable_out <= 1'b0;
            flp_word_out <= 16'h0;
            tx_quiet_out <= 1'b1;
            mode_out <= '0;
        end else if (ce_in) begin
            if (reg_req_in.rd)
                reg_rdata_out <= rd_mux;
            flp_enable_out <= state_r == anc_pkg::ANC_ABILITY;
            flp_word_out <= advert_r;
            tx_quiet_out <= state_r == anc_pkg::ANC_BREAK || !straps_loaded_r;
            mode_out <= '{speed_100: cur_100, full_duplex: cur_full, link_up: cur_link, an_complete: done};
        end
    end

endmodule

/* File: rtl/anc_defines.svh */
`ifndef ANC_DEFINES_SVH
`define ANC_DEFINES_SVH

// register offsets
`define ANC_OFS_CONTROL 5'h00
`define ANC_OFS_STATUS 5'h01
`define ANC_OFS_ADVERT 5'h04
`define ANC_OFS_PARTNER 5'h05
`define ANC_OFS_EXPANSION 5'h06
`define ANC_OFS_SUMMARY 5'h10

// basic_control fields
`define ANC_CTL_SPEED 13
`define ANC_CTL_NEGOTIATE_STRAP_ENABLE 12
`define ANC_CTL_RESTART 9
`define ANC_CTL_DUPLEX 8
`define ANC_CTL_RESET_VAL 16'h3100

// ability bits shared by advert and partner words
`define ANC_ABL_LO 5
`define ANC_ABL_HI 8
`define ANC_ABL_10H 5
`define ANC_ABL_10F 6
`define ANC_ABL_100H 7
`define ANC_ABL_100F 8
`define ANC_PG_NEXT 15
`define ANC_PG_ACK 14
`define ANC_PG_RFAULT 13
`define ANC_SELECTOR 16'h0001
`define ANC_PD_100_WORD 16'h0081
`define ANC_PD_10_WORD 16'h0021

// strap-selected advertised patterns, bits 8:5
`define ANC_ADV_10_BOTH 4'h3
`define ANC_ADV_100_BOTH 4'hc
`define ANC_ADV_HALF_ONLY 4'h5
`define ANC_ADV_ALL 4'hf

// basic_status fixed abilities and live bits
`define ANC_STS_FIXED 16'h7849
`define ANC_STS_AN_DONE 5
`define ANC_STS_RFAULT 4
`define ANC_STS_LINK 2

// negotiation_expansion fields
`define ANC_EXP_PD_FAULT 4
`define ANC_EXP_LP_NP 3
`define ANC_EXP_PAGE_RX 1
`define ANC_EXP_LP_AN 0

// phy_status_summary fields
`define ANC_SUM_LINK 0
`define ANC_SUM_SPEED10 1
`define ANC_SUM_DUPLEX 2
`define ANC_SUM_AN_DONE 4

// timing
`define ANC_CLK_HZ 40000000
`define ANC_BREAK_LINK_MS 1500
`define ANC_STRAP_SETTLE 3'h5

`endif

/* File: rtl/anc_pkg.sv */
package anc_pkg;

    // negotiation sequencer states
    typedef enum logic [1:0] {
        ANC_FORCED,
        ANC_BREAK,
        ANC_ABILITY,
        ANC_COMPLETE
    } anc_state_t;

    // resolved operating mode
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic link_up;
        logic an_complete;
    } anc_mode_t;

    // register access request
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } anc_reg_req_t;

endpackage

/* File: tb/anc_autoneg_ctrl_properties.sv */
module anc_autoneg_ctrl_properties #(
    parameter int BREAK_LINK_MS = 1
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // watched ports
    input wire anc_pkg::anc_reg_req_t reg_req_in,
    input wire anc_pkg::anc_mode_t mode_out,
    input wire logic [15:0] reg_rdata_out,
    input wire logic flp_enable_out,
    input wire logic tx_quiet_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    // request decodes
    wire logic st_rd = reg_req_in.rd && reg_req_in.addr == 5'h01;
    wire logic sm_rd = reg_req_in.rd && reg_req_in.addr == 5'h10;
    wire logic wr_rst = reg_req_in.wr && reg_req_in.addr == 5'h00 && reg_req_in.wdata[9] && reg_req_in.wdata[12];

    property p_quiet_no_flp;
        tx_quiet_out |-> !flp_enable_out;
    endproperty
    a_quiet_no_flp: assert property (p_quiet_no_flp) else $error("bursts while quiet");
    property p_restart;
        wr_rst && mode_out.an_complete |-> ##[1:3] tx_quiet_out;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not silence");
    property p_quiet_hold;
        $rose(tx_quiet_out) |=> tx_quiet_out [*8];
    endproperty
    a_quiet_hold: assert property (p_quiet_hold) else $error("break too short");
    property p_done_no_flp;
        mode_out.an_complete |-> !flp_enable_out;
    endproperty
    a_done_no_flp: assert property (p_done_no_flp) else $error("bursts after done");
    property p_sts_fixed;
        st_rd |=> (reg_rdata_out & 16'hffcb) == 16'h7849;
    endproperty
    a_sts_fixed: assert property (p_sts_fixed) else $error("status ability bits");
    property p_sts_done;
        st_rd |=> reg_rdata_out[5] == $past(mode_out.an_complete);
    endproperty
    a_sts_done: assert property (p_sts_done) else $error("status done bit");
    property p_sum_done;
        sm_rd && mode_out.an_complete |=> reg_rdata_out[4] && reg_rdata_out[2] == $past(mode_out.full_duplex)
            && reg_rdata_out[1] == !$past(mode_out.speed_100);
    endproperty
    a_sum_done: assert property (p_sum_done) else $error("summary result");
    property p_sum_open;
        sm_rd && flp_enable_out |=> reg_rdata_out[2:1] == 2'b00;
    endproperty
    a_sum_open: assert property (p_sum_open) else $error("summary while open");
endmodule

bind anc_autoneg_ctrl anc_autoneg_ctrl_properties #(.BREAK_LINK_MS(BREAK_LINK_MS)) u_props (.*);

/* File: tb/anc_link_partner.sv */
module anc_link_partner (
    // setup from bench
    input wire logic sys_clk_in,
    input wire logic an_able_in,
    input wire logic [3:0] ability_in,
    input wire logic [1:0] pd_link_in,
    input wire logic cut_in,
    // from device transmitter
    input wire logic flp_enable_in,
    input wire logic [15:0] flp_word_in,
    input wire logic tx_quiet_in,
    // toward device
    output logic page_valid_out = 1'b0,
    output logic [15:0] page_word_out = 16'h0,
    output logic link_10_out,
    output logic link_100_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] dly_r = 3'h0;
    logic nego_r = 1'b0;
    wire logic [15:0] base_word = {3'h2, 4'h0, ability_in, 5'h01};
    wire logic [3:0] common = ability_in & flp_word_in[8:5];
    // one base page every eight enabled cycles, word toggles when not valid
    always @(posedge sys_clk_in) begin
        dly_r <= flp_enable_in ? dly_r + 3'h1 : 3'h0;
        page_valid_out <= an_able_in && flp_enable_in && dly_r == 3'h4;
        page_word_out <= dly_r == 3'h4 ? base_word : ~page_word_out;
        nego_r <= !tx_quiet_in && (nego_r || (an_able_in && flp_enable_in && dly_r == 3'h2));
    end
    // link of the resolved or fixed technology, cut drops both, silence only the resolved one
    assign link_100_out = !cut_in && (pd_link_in[1] || (nego_r && |common[3:2]));
    assign link_10_out = !cut_in && (pd_link_in[0] || (nego_r && !(|common[3:2]) && |common));
endmodule

/* File: tb/anc_tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic en = 1'b0, hi = 1'b0, lo = 1'b0, an_able = 1'b0, cut = 1'b0;
    logic [3:0] ability = 4'h0;
    logic [1:0] pd = 2'b00;
    anc_pkg::anc_reg_req_t req = '0;
    anc_pkg::anc_mode_t mode_out;
    logic [15:0] reg_rdata_out, flp_word_out, page_word, d;
    logic flp_enable_out, tx_quiet_out, page_valid, l10, l100;
    int bad_count = 0, tests_run = 0, cyc = 0, n;
    wire logic [2:0] ev = {tx_quiet_out, mode_out.an_complete, flp_enable_out};
    localparam logic [15:0] PAT = 16'hf5c3;
    always #12.5 sys_clk_in = ~sys_clk_in;
    anc_autoneg_ctrl #(.BREAK_LINK_MS(1), .CLK_HZ(40000)) u_anc_autoneg_ctrl (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(1'b1), .negotiate_strap_enable_in(en), .mode_strap_high_in(hi), .mode_strap_low_in(lo),
        .link_10_good_in(l10), .link_100_good_in(l100), .page_valid_in(page_valid), .page_word_in(page_word),
        .reg_req_in(req), .mode_out(mode_out), .reg_rdata_out(reg_rdata_out), .flp_enable_out(flp_enable_out),
        .flp_word_out(flp_word_out), .tx_quiet_out(tx_quiet_out));
    anc_link_partner u_anc_link_partner (.sys_clk_in(sys_clk_in), .an_able_in(an_able), .ability_in(ability),
        .pd_link_in(pd), .cut_in(cut), .flp_enable_in(flp_enable_out), .flp_word_in(flp_word_out),
        .tx_quiet_in(tx_quiet_out), .page_valid_out(page_valid), .page_word_out(page_word),
        .link_10_out(l10), .link_100_out(l100));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reset_dut(input logic e, input logic [1:0] s);
        @(negedge sys_clk_in);
        reset_n_in = 1'b0;
        {en, hi, lo} = {e, s};
        repeat (6) @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        repeat (12) @(negedge sys_clk_in);
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] v);
        @(negedge sys_clk_in);
        req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(negedge sys_clk_in);
        req.wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [4:0] a, output logic [15:0] v);
        @(negedge sys_clk_in);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge sys_clk_in);
        req.rd = 1'b0;
        v = reg_rdata_out;
    endtask
    task automatic wait_on(input int sel, input int lim, output int k);
        k = 0;
        while (k < lim && ev[sel] !== 1'b1) begin
            @(negedge sys_clk_in);
            k++;
        end
    endtask
    task automatic t_forced;
        for (int s = 0; s < 4; s++) begin
            reset_dut(1'b0, 2'(s));
            chk("forced", 16'(s), 16'({mode_out.speed_100, mode_out.full_duplex}));
            reg_rd(5'h00, d);
            chk("ctrl", 16'h3100, d);
        end
        reg_wr(5'h00, 16'h1000);
        repeat (3) @(negedge sys_clk_in);
        chk("en_blocked", 16'h0, 16'(tx_quiet_out));
        reg_wr(5'h00, 16'h0000);
        repeat (4) @(negedge sys_clk_in);
        chk("sw_mode", 16'h0, 16'({mode_out.speed_100, mode_out.full_duplex}));
        reg_wr(5'h00, 16'h1000);
        repeat (3) @(negedge sys_clk_in);
        chk("en_taken", 16'h1, 16'(tx_quiet_out));
        reg_rd(5'h1f, d);
        chk("unmapped", 16'h0, d);
    endtask
    task automatic t_advert;
        for (int s = 0; s < 4; s++) begin
            reset_dut(1'b1, 2'(s));
            wait_on(0, 60, n);
            chk("flp_on", 16'h1, 16'(flp_enable_out));
            chk("flp_word", {7'h0, PAT[s*4+:4], 5'h01}, flp_word_out);
            reg_rd(5'h10, d);
            chk("sum_open", 16'h0, d);
            reg_rd(5'h04, d);
            chk("advert", {7'h0, PAT[s*4+:4], 5'h01}, d);
            reg_rd(5'h01, d);
            chk("status", 16'h7849, d);
        end
    endtask
    task automatic t_negotiate;
        an_able = 1'b1;
        ability = 4'h3;
        reset_dut(1'b1, 2'h3);
        wait_on(1, 60, n);
        chk("mode", 16'h3, 16'({mode_out.speed_100, mode_out.full_duplex, mode_out.an_complete}));
        reg_rd(5'h05, d);
        chk("partner", 16'h4061, d);
        reg_rd(5'h06, d);
        chk("lp_able", 16'h1, 16'(d[0]));
        reg_rd(5'h10, d);
        chk("summary", 16'h0017, d);
        reg_wr(5'h04, 16'h0021);
        reg_wr(5'h00, 16'h1200);
        wait_on(0, 200, n);
        chk("break_len", 16'h1, 16'(n >= 40 && n <= 44));
        wait_on(1, 60, n);
        chk("mode_sup", 16'h1, 16'({mode_out.speed_100, mode_out.full_duplex, mode_out.an_complete}));
        cut = 1'b1;
        wait_on(2, 20, n);
        chk("relink", 16'h1, 16'(tx_quiet_out));
        cut = 1'b0;
        an_able = 1'b0;
    endtask
    task automatic t_parallel;
        for (int i = 0; i < 3; i++) begin
            pd = 2'(i + 1);
            reset_dut(1'b1, 2'h3);
            wait_on(1, 60, n);
            reg_rd(5'h05, d);
            if (i < 2) chk("pd_word", i == 0 ? 16'h0021 : 16'h0081, d);
            reg_rd(5'h06, d);
            chk("pd_fault", 16'({i == 2, 1'b0}), 16'({d[4], d[0]}));
            reg_rd(5'h01, d);
            chk("pd_done", 16'(i < 2), 16'(d[5]));
        end
        pd = 2'b00;
    endtask
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    initial begin
        t_forced;
        t_advert;
        t_negotiate;
        t_parallel;
        tally_and_finish;
    end
endmodule
